// *** core/ipm_regs.sv ***
// Purpose: posted flags, enables, soft posting and vector register of an interrupt controller over APB
// Assumes: pclk 100 MHz, sources give one-cycle or level conditions synchronous to pclk
// Notes: one wait-state APB slave; unmapped reads return zero with pslverr high
// Operation
// [R01] reading a clear register shows every currently posted source
// [R02] soft post off: written zero clears the posted flag, one keeps it
// [R03] soft post on: written zero ignored, written one posts the source
// [R04] software post enable lives in bit 7 of register at 0xde
// [R05] disabled source cannot become pending yet still posts
// [R06] enabled posted source becomes pending
// [R07] each enable bit independent; writes touch only their own bits
// [R08] port pin sources post on detected edge, not on level
// [R09] vector register at 0xe2 reads top-priority pending vector
// [R10] any write to vector register clears all pending interrupts
// [R11] clear register 0 bit layout: port1,sleep,ext1,port0,rx,tx,-,por
// [R12] clear register 1: bit 6 interval timer, bit 5 1 ms timer
// [R13] clear register 2: bit 4 port2, bit 2 ext two, bit 1 counter wrap
// [R14] enable register 0 at 0xe0 matches clear register 0 layout
// [R15] enable register 1 at 0xe1: bit 6 interval, bit 5 1 ms
// [R16] enable register 2 at 0xdf: bit 4 port2, bit 2 ext two, bit 1 wrap
// [R17] posted flag stays until taken or cleared by software
// [R18] pending feed priority encoder; core takes it only with global enable
// [R19] clearing enable neither drops a posted flag nor blocks posting
// [R20] reserved bits read zero and ignore writes
// [R21] software posted interrupts behave exactly like hardware ones
`timescale 1ns/10ps
`include "ipm_map.svh"
module ipm_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ipm_pkg::ipm_src_t src_event,
   input wire ipm_pkg::ipm_src_t src_is_edge,
   input wire logic global_irq_enable,
   input wire logic irq_ack,
   output logic irq_req,
   output ipm_pkg::ipm_vec_t irq_vector
);
   import ipm_pkg::*;

   typedef enum logic [1:0] {
      IPM_IDLE = 2'b01,
      IPM_DONE = 2'b10
   } ipm_state_e;

   // word index of an APB address, or 8'h00 for misaligned / out of range
   function automatic ipm_byte_t word_idx(input logic [31:0] a);
      if (a[1:0] != 2'b00 || a[31:10] != 22'h0) begin
         word_idx = 8'h00;
      end else begin
         word_idx = a[9:2];
      end
   endfunction : word_idx

   // valid-bit mask of a posted/enable group
   function automatic ipm_byte_t group_valid(input int g);
      case (g)
         0: group_valid = `IPM_VALID0;
         1: group_valid = `IPM_VALID1;
         default: group_valid = `IPM_VALID2;
      endcase
   endfunction : group_valid

   ipm_state_e state_r;
   ipm_src_t posted_r;
   ipm_src_t enable_r;
   logic swen_r;
   ipm_src_t src_prev_r;
   ipm_src_t hw_post;
   ipm_src_t pending;
   ipm_vec_t top_vec;
   ipm_byte_t idx;
   logic access;
   logic wr_go;
   logic rd_go;
   logic mapped;
   ipm_byte_t wbyte;
   ipm_src_t sw_set;
   ipm_src_t sw_clr;
   ipm_src_t flush;
   ipm_src_t ack_clr;
   ipm_src_t posted_nxt;
   ipm_byte_t rd_nxt;

   assign idx = word_idx(paddr);
   assign access = psel && penable && state_r == IPM_IDLE;
   assign wr_go = access && pwrite;
   assign rd_go = access && !pwrite;
   assign wbyte = pstrb[0] ? pwdata[7:0] : 8'hff;

   always_comb begin
      unique case (idx)
         `IPM_IDX_CLR0, `IPM_IDX_CLR1, `IPM_IDX_CLR2, `IPM_IDX_SWCTL,
         `IPM_IDX_EN2, `IPM_IDX_EN0, `IPM_IDX_EN1, `IPM_IDX_VEC: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // level sources post while high, edge sources on a rising edge only
   assign hw_post = src_event & (~src_is_edge | ~src_prev_r); // [R08]
   // masking gates only the pending path
   assign pending = posted_r & enable_r; // [R05] [R06] [R19]

   ipm_prio u_prio (
      .pending(pending), // [R18]
      .vector(top_vec)
   );

   // software writes to a clear register
   always_comb begin
      sw_set = '0;
      sw_clr = '0;
      for (int g = 0; g < 3; g++) begin
         if (wr_go && pstrb[0] && idx == 8'(`IPM_IDX_CLR0 + g)) begin // [R11] [R12] [R13]
            for (int b = 0; b < 8; b++) begin
               if (group_valid(g)[b]) begin // [R20]
                  if (swen_r) begin
                     sw_set[g*8+b] = wbyte[b]; // [R03] [R21]
                  end else begin
                     sw_clr[g*8+b] = !wbyte[b]; // [R02]
                  end
               end
            end
         end
      end
   end

   assign flush = (wr_go && idx == `IPM_IDX_VEC) ? pending : '0; // [R10]

   // vector each source would give alone, to match the one the core took
   ipm_vec_t solo_vec [`IPM_NSRC];
   for (genvar s = 0; s < `IPM_NSRC; s++) begin : g_solo
      ipm_prio u_solo (
         .pending(ipm_src_t'(24'h000001 << s)),
         .vector(solo_vec[s])
      );
   end

   // a taken interrupt drops its own posted flag
   always_comb begin
      ack_clr = '0;
      for (int i = 0; i < `IPM_NSRC; i++) begin
         if (irq_ack && pending[i] && irq_vector != 8'h00 && solo_vec[i] == irq_vector) begin // [R17]
            ack_clr[i] = 1'b1;
         end
      end
   end

   // hardware and software posting win over any clear in the same cycle
   assign posted_nxt = ((posted_r & ~(sw_clr | flush | ack_clr)) | hw_post | sw_set) &
                       {group_valid(2), group_valid(1), group_valid(0)}; // [R17] [R20]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         posted_r <= '0;
         src_prev_r <= '0;
      end else begin
         posted_r <= posted_nxt;
         src_prev_r <= src_event;
      end
   end

   // enable registers and software post enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_r <= '0;
         swen_r <= 1'b0;
      end else if (wr_go && pstrb[0]) begin
         unique case (idx)
            `IPM_IDX_EN0: enable_r[7:0] <= pwdata[7:0] & `IPM_VALID0; // [R14] [R07]
            `IPM_IDX_EN1: enable_r[15:8] <= pwdata[7:0] & `IPM_VALID1; // [R15] [R07]
            `IPM_IDX_EN2: enable_r[23:16] <= pwdata[7:0] & `IPM_VALID2; // [R16] [R07]
            `IPM_IDX_SWCTL: swen_r <= pwdata[`IPM_SWEN_BIT]; // [R04]
            default: ;
         endcase
      end
   end

   always_comb begin
      rd_nxt = 8'h00;
      unique case (idx)
         `IPM_IDX_CLR0: rd_nxt = posted_r[7:0]; // [R01]
         `IPM_IDX_CLR1: rd_nxt = posted_r[15:8]; // [R01]
         `IPM_IDX_CLR2: rd_nxt = posted_r[23:16]; // [R01]
         `IPM_IDX_SWCTL: rd_nxt = {swen_r, 7'h00}; // [R20]
         `IPM_IDX_EN0: rd_nxt = enable_r[7:0];
         `IPM_IDX_EN1: rd_nxt = enable_r[15:8];
         `IPM_IDX_EN2: rd_nxt = enable_r[23:16];
         `IPM_IDX_VEC: rd_nxt = top_vec; // [R09]
         default: rd_nxt = 8'h00;
      endcase
   end

   // apb answer: one access cycle, then ready for one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= IPM_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         unique case (state_r)
            IPM_IDLE: begin
               pready <= access;
               pslverr <= access && !mapped;
               if (rd_go) begin
                  prdata <= {24'h0, rd_nxt};
               end
               if (access) begin
                  state_r <= IPM_DONE;
               end
            end
            IPM_DONE: begin
               pready <= 1'b0;
               pslverr <= 1'b0;
               state_r <= IPM_IDLE;
            end
         endcase
      end
   end

   // request to the core, gated by its global enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_req <= 1'b0;
         irq_vector <= `IPM_RESET_VAL;
      end else begin
         irq_req <= global_irq_enable && (pending & ~ack_clr & ~flush) != '0; // [R18]
         irq_vector <= top_vec;
      end
   end

   a_flush_clears: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
      flush != '0 |=> (posted_r & $past(flush)) == ($past(hw_post | sw_set) & $past(flush)))
      else $error("vector write did not clear pending");
   a_sw_post: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
      sw_set != '0 |=> (posted_r & $past(sw_set)) == $past(sw_set))
      else $error("software post lost");
   a_sw_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
      (sw_clr & ~hw_post) != '0 |=> (posted_r & $past(sw_clr & ~hw_post)) == '0)
      else $error("software clear failed");
   a_mask_keep: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
      $fell(enable_r[0]) && $past(posted_r[0]) && !$past(sw_clr[0] | flush[0] | ack_clr[0]) |-> posted_r[0])
      else $error("mask cleared a posted flag");
   a_pend_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R05]
      (posted_r & enable_r) == '0 |=> irq_vector == 8'h00 && !irq_req)
      else $error("masked source pending");
   a_edge_post: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
      src_is_edge[7] && src_event[7] && src_prev_r[7] && !posted_r[7] && !sw_set[7] |=> !posted_r[7])
      else $error("edge source posted on level");
   a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
      (posted_r & ~{`IPM_VALID2, `IPM_VALID1, `IPM_VALID0}) == '0 && enable_r[1] == 1'b0)
      else $error("reserved bit set");
   a_read_posted: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
      rd_go && idx == `IPM_IDX_CLR0 |=> prdata[7:0] == $past(posted_r[7:0]) && pready)
      else $error("clear register read wrong");
   a_vec_read: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
      rd_go && idx == `IPM_IDX_VEC |=> prdata[7:0] == $past(top_vec))
      else $error("vector read wrong");
   a_req_gie: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
      !$past(global_irq_enable) |-> !irq_req)
      else $error("request without global enable");

   a_swen_write: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
      wr_go && pstrb[0] && idx == `IPM_IDX_SWCTL
      |=> swen_r == $past(pwdata[`IPM_SWEN_BIT]))
      else $error("software post enable not written");
   a_swctl_read: assert property (@(posedge pclk) disable iff (!presetn) // [R04] [R20]
      rd_go && idx == `IPM_IDX_SWCTL
      |=> prdata == {24'h0, $past(swen_r), 7'h00})
      else $error("software post control read wrong");
   a_en0_write: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
      wr_go && pstrb[0] && idx == `IPM_IDX_EN0
      |=> enable_r[7:0] == ($past(pwdata[7:0]) & `IPM_VALID0))
      else $error("enable register 0 write wrong");
   a_en1_write: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
      wr_go && pstrb[0] && idx == `IPM_IDX_EN1
      |=> enable_r[15:8] == ($past(pwdata[7:0]) & `IPM_VALID1))
      else $error("enable register 1 write wrong");
   a_en2_write: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
      wr_go && pstrb[0] && idx == `IPM_IDX_EN2
      |=> enable_r[23:16] == ($past(pwdata[7:0]) & `IPM_VALID2))
      else $error("enable register 2 write wrong");
   a_en_other: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
      wr_go && idx == `IPM_IDX_EN0
      |=> enable_r[23:8] == $past(enable_r[23:8]))
      else $error("enable write touched another group");
   a_en_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
      !wr_go
      |=> enable_r == $past(enable_r))
      else $error("enable changed without a write");
   a_post_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
      posted_r != '0
      |=> ($past(posted_r & ~(sw_clr | flush | ack_clr)) & ~posted_r) == '0)
      else $error("posted flag dropped without a clear");
   a_edge_rise: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
      src_is_edge[7] && src_event[7] && !src_prev_r[7]
      |=> posted_r[7])
      else $error("edge source did not post");
   a_level_post: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
      !src_is_edge[0] && src_event[0]
      |=> posted_r[0])
      else $error("level source did not post");
   a_sw_ignore: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
      swen_r && wr_go && idx == `IPM_IDX_CLR0 && !irq_ack
      |=> (posted_r[7:0] & $past(posted_r[7:0])) == $past(posted_r[7:0]))
      else $error("written zero cleared a flag during soft post");
   a_one_keep: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
      !swen_r && wr_go && idx == `IPM_IDX_CLR0 && !irq_ack
      |=> (posted_r[7:0] & $past(posted_r[7:0] & pwdata[7:0])) == $past(posted_r[7:0] & pwdata[7:0]))
      else $error("written one cleared a flag");
   a_vec_none: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
      pending == '0
      |-> top_vec == 8'h00)
      else $error("vector without pending source");
   a_vec_top: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
      pending[0]
      |-> top_vec == 8'h04)
      else $error("top source not chosen");
   a_vec_reg: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
      irq_req
      |-> irq_vector == $past(top_vec) && irq_vector != 8'h00)
      else $error("request vector wrong");
   a_req_pend: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
      global_irq_enable && (pending & ~ack_clr & ~flush) != '0
      |=> irq_req)
      else $error("pending source not requested");
   a_ack_timer: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
      irq_ack && pending[13] && irq_vector == 8'h34 && !hw_post[13] && !sw_set[13]
      |=> !posted_r[13])
      else $error("taken timer flag kept");
   a_ack_sleep: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
      irq_ack && pending[6] && irq_vector == 8'h64 && !hw_post[6] && !sw_set[6]
      |=> !posted_r[6])
      else $error("taken sleep flag kept");
   a_flush_masked: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
      flush != '0
      |=> (posted_r & $past(posted_r & ~enable_r)) == $past(posted_r & ~enable_r))
      else $error("vector write dropped a masked flag");
   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
      access && !mapped
      |=> pslverr && pready)
      else $error("unmapped access not refused");
   a_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
      rd_go && !mapped
      |=> prdata == 32'h0)
      else $error("unmapped read not zero");
endmodule : ipm_regs

// *** common/ipm_map.svh ***
// Purpose: register offsets, field positions and reset values of the interrupt post/mask block
// Assumes: byte offsets as printed are the register indices; byte address is four times the index
// Notes: reserved bits read as zero
`ifndef IPM_MAP_SVH
`define IPM_MAP_SVH
`define IPM_IDX_CLR0 8'hda
`define IPM_IDX_CLR1 8'hdb
`define IPM_IDX_CLR2 8'hdc
`define IPM_IDX_SWCTL 8'hde
`define IPM_IDX_EN2 8'hdf
`define IPM_IDX_EN0 8'he0
`define IPM_IDX_EN1 8'he1
`define IPM_IDX_VEC 8'he2
`define IPM_VALID0 8'hfd
`define IPM_VALID1 8'h60
`define IPM_VALID2 8'h16
`define IPM_VALID3 8'h80
`define IPM_SWEN_BIT 7
`define IPM_RESET_VAL 8'h00
`define IPM_NSRC 24
`define IPM_VEC_STEP 8'h04
`define IPM_PRIO_BASE 8'h01
`endif

// *** common/ipm_pkg.sv ***
// Purpose: shared types of the interrupt post/mask block
// Assumes: nothing beyond the map header
// Notes: one flat source vector, index = group*8 + bit
package ipm_pkg;
   typedef logic [7:0] ipm_byte_t;
   typedef logic [23:0] ipm_src_t;
   typedef logic [7:0] ipm_vec_t;
endpackage : ipm_pkg

// *** core/ipm_prio.sv ***
// Purpose: priority encoder from pending sources to an interrupt vector
// Assumes: source index = group*8 + bit, priority table fixed in the design
// Notes: lower priority number wins; zero vector when nothing pends
`timescale 1ns/10ps
`include "ipm_map.svh"
module ipm_prio (
   input wire ipm_pkg::ipm_src_t pending,
   output ipm_pkg::ipm_vec_t vector
);
   import ipm_pkg::*;

   // priority number of each source index, zero for reserved positions
   function automatic ipm_vec_t prio_of(input int idx);
      case (idx)
         0: prio_of = 8'h01;
         2: prio_of = 8'h03;
         3: prio_of = 8'h04;
         4: prio_of = 8'h05;
         7: prio_of = 8'h06;
         5: prio_of = 8'h07;
         13: prio_of = 8'h0d;
         14: prio_of = 8'h0e;
         17: prio_of = 8'h11;
         18: prio_of = 8'h12;
         20: prio_of = 8'h14;
         6: prio_of = 8'h19;
         default: prio_of = 8'h00;
      endcase
   endfunction : prio_of

   ipm_vec_t best;
   always_comb begin
      best = 8'hff;
      for (int i = 0; i < `IPM_NSRC; i++) begin
         if (pending[i] && prio_of(i) != 8'h00 && prio_of(i) < best) begin
            best = prio_of(i);
         end
      end
      // vector address = priority * 4
      vector = (best == 8'hff) ? 8'h00 : 8'((best * `IPM_VEC_STEP) & 8'hff);
   end
endmodule : ipm_prio

// *** tb/ipm_core_model.sv ***
// Purpose: processor core model that takes interrupt vectors
// Assumes: irq_req and irq_vector are registered by the block
// Notes: drops its global enable when it takes a vector, as a real core does
`timescale 1ns/10ps
module ipm_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic gie_set,
   input wire logic [3:0] ack_delay,
   input wire logic irq_req,
   input wire ipm_pkg::ipm_vec_t irq_vector,
   output logic global_irq_enable,
   output logic irq_ack,
   output ipm_pkg::ipm_vec_t taken_vec,
   output logic taken
);
   import ipm_pkg::*;
   logic [3:0] wait_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_irq_enable <= 1'b0;
         irq_ack <= 1'b0;
         taken_vec <= 8'h00;
         taken <= 1'b0;
         wait_r <= 4'h0;
      end else begin
         irq_ack <= 1'b0;
         if (gie_set) begin
            global_irq_enable <= 1'b1;
            taken <= 1'b0;
         end
         if (global_irq_enable && irq_req && !irq_ack) begin
            if (wait_r == ack_delay) begin
               irq_ack <= 1'b1;
               taken_vec <= irq_vector;
               taken <= 1'b1;
               global_irq_enable <= 1'b0;
               wait_r <= 4'h0;
            end else begin
               wait_r <= wait_r + 4'h1;
            end
         end
      end
   end
endmodule : ipm_core_model

// *** tb/test_interrupt_post_mask_regs.sv ***
// Purpose: register-level tests of the interrupt post/mask block
// Assumes: apb slave answers in its own time; core model takes vectors
// Notes: expected values come from the bit layouts and the priority table
`timescale 1ns/10ps
module test_interrupt_post_mask_regs;
   import ipm_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata;
   ipm_src_t src_event, src_is_edge;
   logic gie_set, global_irq_enable, irq_ack, irq_req, taken;
   logic [3:0] ack_delay;
   ipm_vec_t irq_vector, taken_vec, rd;
   int errors, checks;
   logic [7:0] regs [8] = '{8'hda, 8'hdb, 8'hdc, 8'hde, 8'hdf, 8'he0, 8'he1, 8'he2};
   logic [7:0] masks [8] = '{8'hfd, 8'h60, 8'h16, 8'h80, 8'h16, 8'hfd, 8'h60, 8'h00};
   ipm_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_event(src_event), .src_is_edge(src_is_edge), .global_irq_enable(global_irq_enable),
      .irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector));
   ipm_core_model core (.pclk(pclk), .presetn(presetn), .gie_set(gie_set), .ack_delay(ack_delay),
      .irq_req(irq_req), .irq_vector(irq_vector), .global_irq_enable(global_irq_enable),
      .irq_ack(irq_ack), .taken_vec(taken_vec), .taken(taken));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task finish_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test
   task check8(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s exp %h got %h", name, exp, got);
      end
   endtask : check8
   task check1(input string name, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s exp %b got %b", name, exp, got);
      end
   endtask : check1
   task apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {22'h0, idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         errors++;
         finish_test();
      end
      @(posedge pclk);
   endtask : apb
   task wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask : wr
   task rdc(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      check8($sformatf("register %h", idx), exp, rd);
   endtask : rdc
   task wait_take(input logic [7:0] exp);
      int n;
      gie_set <= 1'b1;
      @(posedge pclk);
      gie_set <= 1'b0;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (taken !== 1'b1 && n < 50);
      if (taken !== 1'b1) begin
         errors++;
         finish_test();
      end
      check8("taken vector", exp, taken_vec);
   endtask : wait_take
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      src_event = '0;
      src_is_edge = '0;
      gie_set = 1'b0;
      ack_delay = 4'h0;
      errors = 0;
      checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 8; i++) rdc(regs[i], 8'h00);
      for (int i = 3; i < 7; i++) wr(regs[i], 8'hff);
      for (int i = 3; i < 7; i++) rdc(regs[i], masks[i]);
      for (int i = 4; i < 7; i++) wr(regs[i], 8'h00);
      $display("test enables done");
      wr(8'hda, 8'h01);
      wr(8'hda, 8'hfc);
      rdc(8'hda, 8'hfd);
      wr(8'hdb, 8'hff);
      rdc(8'hdb, 8'h60);
      wr(8'hdc, 8'hff);
      rdc(8'hdc, 8'h16);
      wr(8'hde, 8'h00);
      wr(8'hda, 8'hff);
      rdc(8'hda, 8'hfd);
      wr(8'hda, 8'h7e);
      rdc(8'hda, 8'h7c);
      for (int i = 0; i < 3; i++) wr(regs[i], 8'h00);
      for (int i = 0; i < 3; i++) rdc(regs[i], 8'h00);
      $display("test soft post done");
      src_is_edge <= 24'h000080;
      src_event[7] <= 1'b1;
      repeat (3) @(posedge pclk);
      rdc(8'hda, 8'h80);
      wr(8'hda, 8'h7f);
      repeat (3) @(posedge pclk);
      rdc(8'hda, 8'h00);
      src_event <= 24'h000001;
      @(posedge pclk);
      src_event[0] <= 1'b0;
      repeat (3) @(posedge pclk);
      rdc(8'hda, 8'h01);
      wr(8'hda, 8'h00);
      $display("test hardware post done");
      wr(8'hde, 8'h80);
      wr(8'hda, 8'h45);
      wr(8'hdc, 8'h02);
      rdc(8'he2, 8'h00);
      wr(8'he0, 8'h04);
      rdc(8'he2, 8'h0c);
      wr(8'he0, 8'h05);
      wr(8'hdf, 8'h02);
      rdc(8'he2, 8'h04);
      wr(8'he0, 8'h04);
      rdc(8'hda, 8'h45);
      rdc(8'he2, 8'h0c);
      wr(8'he0, 8'h05);
      wr(8'he2, 8'h5a);
      rdc(8'hda, 8'h40);
      rdc(8'hdc, 8'h00);
      rdc(8'he2, 8'h00);
      $display("test vector done");
      wr(8'he1, 8'h20);
      wr(8'hdb, 8'h20);
      check1("request", 1'b0, irq_req);
      wait_take(8'h34);
      rdc(8'hdb, 8'h00);
      ack_delay <= 4'h5;
      wr(8'he0, 8'h40);
      wait_take(8'h64);
      rdc(8'hda, 8'h00);
      $display("test core take done");
      apb(1'b0, 8'hd9, 8'h00);
      check1("slave error", 1'b1, err);
      check8("unmapped read", 8'h00, rd);
      $display("test unmapped done");
      finish_test();
   end
endmodule : test_interrupt_post_mask_regs
